// [core/acsr_defs.svh]
// register offsets, field positions, reset values and timing of the converter control block
`ifndef ACSR_DEFS_SVH
`define ACSR_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ACSR_OFF_SC1     8'h00
`define ACSR_OFF_SC2     8'h04
`define ACSR_OFF_RH      8'h08
`define ACSR_OFF_RL      8'h0c
`define ACSR_OFF_CV      8'h10
`define ACSR_OFF_CFG     8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACSR_SC1_DONE    7
`define ACSR_SC1_IEN     6
`define ACSR_SC1_CONT    5
`define ACSR_SC1_CH_HI   4
`define ACSR_SC1_CH_LO   0
`define ACSR_SC2_ACT     7
`define ACSR_SC2_TRG     6
`define ACSR_SC2_CMPEN   5
`define ACSR_SC2_CMPGE   4
`define ACSR_CFG_MODE_HI 3
`define ACSR_CFG_MODE_LO 2

// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define ACSR_CH_OFF      5'h1f
`define ACSR_CH_HIGH_REFERENCE_CHANNEL    5'h1d
`define ACSR_CH_LOW_REFERENCE_CHANNEL    5'h1e
`define ACSR_CH_RSVD     5'h1c
`define ACSR_MODE_8      2'h0
`define ACSR_MODE_10     2'h2
`define ACSR_RST_CH      5'h1f
`define ACSR_RST_MODE    2'h0
`define ACSR_RST_CV      10'h000
`define ACSR_RST_RESULT  10'h000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ACSR_CLK_PERIOD_NS 50
`define ACSR_CONV_TIME_NS  2500
`define ACSR_CONV_CYCLES   ((`ACSR_CONV_TIME_NS + `ACSR_CLK_PERIOD_NS - 1) / `ACSR_CLK_PERIOD_NS)

`endif

// [core/acsr_pkg.sv]
// types shared by the converter control block
package acsr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } acsr_state_t;

  typedef logic [9:0] acsr_result_t;

  typedef struct packed {
    acsr_state_t  state;
    logic         ien;
    logic         cont;
    logic [4:0]   ch;
    logic         trg;
    logic         cmpen;
    logic         cmpge;
    logic [1:0]   mode;
    acsr_result_t cv;
    acsr_result_t result;
    logic         done;
    logic         lock;
    logic         irq;
    logic         powered;
    logic [2:0]   trig_sync;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } acsr_regs_t;

endpackage : acsr_pkg

// [core/acsr_conv.sv]
// conversion timer: runs one conversion and captures the sampled value
`timescale 1ns/1ps
`include "acsr_defs.svh"

module acsr_conv #(
  parameter int CYCLES = `ACSR_CONV_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  start,
  input  wire logic                  abort,
  input  wire acsr_pkg::acsr_result_t sample,
  output logic                       done,
  output acsr_pkg::acsr_result_t     result
);
  import acsr_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
    logic             done;
    acsr_result_t     result;
  } acsr_conv_t;

  acsr_conv_t q, d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (abort) begin
      d.busy = 1'b0;
    end
    // a start in the abort cycle restarts from zero
    if (start) begin
      d.busy = 1'b1;
      d.cnt  = '0;
    end else if (q.busy && !abort) begin
      if (q.cnt == CNT_W'(CYCLES - 1)) begin
        d.busy   = 1'b0;
        d.done   = 1'b1;
        d.result = sample;
      end else begin
        d.cnt = q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{busy: 1'b0, cnt: '0, done: 1'b0, result: `ACSR_RST_RESULT};
    end else begin
      q <= d;
    end
  end

  assign done   = q.done;
  assign result = q.result;

endmodule : acsr_conv

// [core/acsr_top.sv]
// control, status and result-high logic of the converter with its APB slave
// Function
// - writing control one aborts any conversion, starts anew unless channel is all ones or the hardware trigger is selected
// - done flag sets per conversion, or only on compare match when compare is on
// - done flag clears on control one write or result low read
// - done flag rising with interrupt enable high raises the interrupt request
// - continuous bit zero gives one conversion per trigger, one repeats conversions
// - channel field selects inputs, reserved code, references, or module off
// - channel all ones switches converter off without any extra conversion
// - without continuous mode converter drops to low power after each conversion
// - active flag sets on conversion start, clears on completion or abort
// - trigger select chooses register write or hardware trigger edge as start
// - control two bit five enables the compare function
// - compare direction picks below or greater-or-equal as the match
// - result high holds upper two result bits, zero in eight-bit mode
// - results load on every completion unless compare is on and fails, or the ten-bit interlock holds
// - ten-bit mode: result high read locks results until result low read
// - eight-bit mode: result reads never lock result transfers
// - mode code 00 gives eight-bit, 10 gives ten-bit conversions
// - compare checks low eight bits always, upper two only in ten-bit mode
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "acsr_defs.svh"

module acsr_top #(
  parameter int ADDR_W = 8,
  parameter int CONV_CYCLES = `ACSR_CONV_CYCLES
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   hardware_trigger_input,
  input  wire acsr_pkg::acsr_result_t conv_sample_value,
  output logic [4:0]                  channel_select,
  output logic                        converter_powered,
  output logic                        conversion_irq
);
  import acsr_pkg::*;

  acsr_regs_t   q, d;
  logic         conv_done;
  acsr_result_t conv_result;
  logic         conv_start;
  logic         sc1_wr;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_reg = (a == ADDR_W'(off));
  endfunction : is_reg

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = is_reg(a, `ACSR_OFF_SC1) || is_reg(a, `ACSR_OFF_SC2) ||
                is_reg(a, `ACSR_OFF_RH)  || is_reg(a, `ACSR_OFF_RL)  ||
                is_reg(a, `ACSR_OFF_CV)  || is_reg(a, `ACSR_OFF_CFG);
  endfunction : is_mapped

  // low eight bits always, upper two only in ten-bit mode
  function automatic logic cmp_match(input acsr_result_t res, input acsr_result_t cv,
                                     input logic ten, input logic ge);
    acsr_result_t a;
    acsr_result_t b;
    a = ten ? res : {2'h0, res[7:0]};
    b = ten ? cv  : {2'h0, cv[7:0]};
    cmp_match = ge ? (a >= b) : (a < b);
  endfunction : cmp_match

  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  logic         setup;
  logic         access;
  logic         rh_rd;
  logic         rl_rd;
  logic         ten_bit;
  logic         complete;
  logic         match;
  logic         hw_rise;
  logic         keep;
  acsr_result_t shaped;

  assign setup    = psel && !penable;
  assign access   = psel && penable && q.pready;
  assign sc1_wr   = access && pwrite && is_reg(paddr, `ACSR_OFF_SC1);
  assign rh_rd    = access && !pwrite && is_reg(paddr, `ACSR_OFF_RH);
  assign rl_rd    = access && !pwrite && is_reg(paddr, `ACSR_OFF_RL);
  assign ten_bit  = (q.mode == `ACSR_MODE_10);
  // an abort in the same cycle discards the finishing conversion
  assign complete = conv_done && !sc1_wr && (q.state == ST_CONV);
  // eight-bit results keep the top eight of the ten sampled bits, right justified
  assign shaped   = ten_bit ? conv_result : {2'h0, conv_result[9:2]};
  assign match    = cmp_match(shaped, q.cv, ten_bit, q.cmpge);
  assign keep     = !q.cmpen || match;
  assign hw_rise  = q.trig_sync[1] && !q.trig_sync[2];

  // ---------------------------------------------------------------
  // start conditions
  // ---------------------------------------------------------------
  always_comb begin
    conv_start = 1'b0;
    if (sc1_wr) begin
      conv_start = (pwdata[`ACSR_SC1_CH_HI:`ACSR_SC1_CH_LO] != `ACSR_CH_OFF) && !q.trg;
    end else if (complete) begin
      conv_start = q.cont && (q.ch != `ACSR_CH_OFF);
    end else if (q.state == ST_IDLE) begin
      // an armed hardware trigger starts one sequence per rising edge
      conv_start = q.trg && hw_rise && (q.ch != `ACSR_CH_OFF);
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.trig_sync = {q.trig_sync[1:0], hardware_trigger_input};

    // no wait state; read data comes from a flop loaded in the setup cycle
    d.pready  = setup;
    d.pslverr = setup && !is_mapped(paddr);
    d.prdata  = 32'h0;
    if (setup && !pwrite) begin
      if (is_reg(paddr, `ACSR_OFF_SC1)) begin
        d.prdata[7:0] = {q.done, q.ien, q.cont, q.ch};
      end
      if (is_reg(paddr, `ACSR_OFF_SC2)) begin
        d.prdata[7:0] = {q.state == ST_CONV, q.trg, q.cmpen, q.cmpge, 4'h0};
      end
      if (is_reg(paddr, `ACSR_OFF_RH)) begin
        d.prdata[7:0] = {6'h0, q.result[9:8]};
      end
      if (is_reg(paddr, `ACSR_OFF_RL)) begin
        d.prdata[7:0] = q.result[7:0];
      end
      if (is_reg(paddr, `ACSR_OFF_CV)) begin
        d.prdata[9:0] = q.cv;
      end
      if (is_reg(paddr, `ACSR_OFF_CFG)) begin
        d.prdata[7:0] = {4'h0, q.mode, 2'h0};
      end
    end

    // register writes
    if (sc1_wr) begin
      d.ien  = pwdata[`ACSR_SC1_IEN];
      d.cont = pwdata[`ACSR_SC1_CONT];
      d.ch   = pwdata[`ACSR_SC1_CH_HI:`ACSR_SC1_CH_LO];
    end
    if (access && pwrite && is_reg(paddr, `ACSR_OFF_SC2)) begin
      d.trg   = pwdata[`ACSR_SC2_TRG];
      d.cmpen = pwdata[`ACSR_SC2_CMPEN];
      d.cmpge = pwdata[`ACSR_SC2_CMPGE];
    end
    if (access && pwrite && is_reg(paddr, `ACSR_OFF_CV)) begin
      d.cv = pwdata[9:0];
    end
    if (access && pwrite && is_reg(paddr, `ACSR_OFF_CFG)) begin
      d.mode = pwdata[`ACSR_CFG_MODE_HI:`ACSR_CFG_MODE_LO];
    end

    // conversion sequencing
    unique case (q.state)
      ST_IDLE: begin
        if (conv_start) begin
          d.state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_start) begin
          d.state = ST_CONV;
        end else if (sc1_wr || complete) begin
          d.state = ST_IDLE;
        end
      end
    endcase
    d.powered = (d.state == ST_CONV);

    // interlock: only a ten-bit result high read arms it
    if (rl_rd) begin
      d.lock = 1'b0;
    end else if (rh_rd && ten_bit) begin
      d.lock = 1'b1;
    end

    // result transfer
    if (complete && keep && !(q.lock && ten_bit)) begin
      d.result = shaped;
    end

    // set wins over clear
    if (sc1_wr || rl_rd) begin
      d.done = 1'b0;
    end
    if (complete && keep) begin
      d.done = 1'b1;
    end
    d.irq = d.done && d.ien;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{state: ST_IDLE, ien: 1'b0, cont: 1'b0, ch: `ACSR_RST_CH, trg: 1'b0,
             cmpen: 1'b0, cmpge: 1'b0, mode: `ACSR_RST_MODE, cv: `ACSR_RST_CV,
             result: `ACSR_RST_RESULT, done: 1'b0, lock: 1'b0, irq: 1'b0,
             powered: 1'b0, trig_sync: 3'h0, pready: 1'b0, pslverr: 1'b0,
             prdata: 32'h0};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // conversion engine
  // ---------------------------------------------------------------
  acsr_conv #(
    .CYCLES (CONV_CYCLES)
  ) u_conv (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (conv_start),
    .abort   (sc1_wr),
    .sample  (conv_sample_value),
    .done    (conv_done),
    .result  (conv_result)
  );

  assign pready            = q.pready;
  assign prdata            = q.prdata;
  assign pslverr           = q.pslverr;
  assign channel_select    = q.ch;
  assign converter_powered = q.powered;
  assign conversion_irq    = q.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sc1_restart_a: assert property (sc1_wr && !q.trg && pwdata[4:0] != 5'h1f
                                  |=> q.state == ST_CONV ##1 q.powered)
    else $error("control one write did not restart a conversion");
  chan_off_a: assert property (sc1_wr && pwdata[4:0] == 5'h1f
                               |=> q.state == ST_IDLE && !q.powered ##1 !q.powered)
    else $error("all-ones channel left the converter running");
  done_set_a: assert property (complete && !q.cmpen |=> q.done)
    else $error("done flag missed a completion");
  done_clear_a: assert property ((sc1_wr || (rl_rd && !complete)) |=> !q.done)
    else $error("done flag not cleared");
  irq_raise_a: assert property ($rose(q.done) && q.ien |-> conversion_irq)
    else $error("interrupt not raised with done flag");
  single_sleep_a: assert property (complete && !q.cont |=> !q.powered && q.state == ST_IDLE)
    else $error("single conversion left converter powered");
  cmp_block_a: assert property (complete && q.cmpen && !match |=> $stable(q.result) && !$rose(q.done))
    else $error("failed compare loaded a result");
  lock_hold_a: assert property (q.lock && !rl_rd && ten_bit |=> q.lock && $stable(q.result))
    else $error("interlocked result changed");
  rh_eight_a: assert property (access && !pwrite && is_reg(paddr, `ACSR_OFF_RH) && q.mode == `ACSR_MODE_8
                               |-> prdata[1:0] == 2'h0)
    else $error("result high nonzero in eight-bit mode");
  apb_wait_a: assert property (setup |=> pready ##1 !pready)
    else $error("slave answer timing wrong");

  cont_restart_c: cover property (complete && q.cont ##1 q.state == ST_CONV);
  hw_start_c: cover property (q.trg && hw_rise && q.state == ST_IDLE ##1 q.powered);
  lock_drop_c: cover property (q.lock && complete);
  cmp_hit_c: cover property (complete && q.cmpen && match);

endmodule : acsr_top

// [testbench/acsr_apb_master.sv]
// apb master model standing in for the processor side of the converter block
`timescale 1ns/1ps
`include "acsr_defs.svh"

module acsr_apb_master (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // -----------------------------------------------------------
  // one transfer; no cycle count assumed, the bench watchdog cuts a hang
  // -----------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    // the two lowest reserved bits of control two always go out as zero
    pwdata <= (a == `ACSR_OFF_SC2) ? (wd & 32'hffff_fffc) : wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : acsr_apb_master

// [testbench/test_adc_control_status_result_high.sv]
// self-checking bench of the converter control, status and result-high block
`timescale 1ns/1ps
`include "acsr_defs.svh"

module test_adc_control_status_result_high;
  import acsr_pkg::*;
  // short conversion keeps the run brief; the conversion waits derive from it
  localparam int CC = 4;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         hw = 1'b0;
  acsr_result_t smp = 10'h000;
  wire          psel, penable, pwrite, pready, pslverr, pwr, irq;
  wire [7:0]    paddr;
  wire [31:0]   pwdata, prdata;
  wire [4:0]    chsel;
  int           err_total = 0;
  int           num_checks = 0;
  integer       seed = 32'hd6f0f872;
  logic [31:0]  rd;
  logic         er;
  logic [4:0]   chs [5] = '{5'h00, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
  logic [1:0]   tg [7] = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b01, 2'b00, 2'b00};
  logic [9:0]   cvs [7] = '{10'h200, 10'h200, 10'h200, 10'h200, 10'h280, 10'h280, 10'h280};
  logic [9:0]   sss [7] = '{10'h1ff, 10'h200, 10'h200, 10'h1ff, 10'h200, 10'h1fc, 10'h204};

  initial begin
    forever #25 pclk = ~pclk;
  end

  acsr_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                     .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  acsr_top #(.ADDR_W(8), .CONV_CYCLES(CC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .hardware_trigger_input(hw),
    .conv_sample_value(smp), .channel_select(chsel), .converter_powered(pwr), .conversion_irq(irq));

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    m.xfer(1'b0, a, 32'h0, rd, er);
    check(rd, e);
  endtask : rdc

  task automatic wait_pw(input logic lvl, input int lim);
    int k;
    k = 0;
    while (pwr !== lvl && k < lim) begin
      @(posedge pclk);
      k++;
    end
    check(pwr, lvl);
  endtask : wait_pw

  task automatic convert(input acsr_result_t s, input logic [7:0] c1);
    smp <= s;
    wr(`ACSR_OFF_SC1, {24'h0, c1});
    wait_pw(1'b1, 8);
    wait_pw(1'b0, CC + 12);
    tick(3);
  endtask : convert

  function automatic logic [9:0] res_of(input logic [9:0] s, input logic ten);
    return ten ? s : {2'b00, s[9:2]};
  endfunction : res_of

  function automatic logic [31:0] rh_of(input logic [9:0] s, input logic ten);
    logic [9:0] r;
    r = res_of(s, ten);
    return {30'h0, r[9:8]};
  endfunction : rh_of

  function automatic logic [31:0] rl_of(input logic [9:0] s, input logic ten);
    logic [9:0] r;
    r = res_of(s, ten);
    return {24'h0, r[7:0]};
  endfunction : rl_of

  function automatic logic hit(input logic [9:0] s, input logic ten, input logic ge, input logic [9:0] cv);
    logic [9:0] r;
    logic [9:0] c;
    r = res_of(s, ten);
    c = ten ? cv : {2'b00, cv[7:0]};
    return ge ? (r >= c) : (r < c);
  endfunction : hit

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  initial begin : main
    logic [4:0] ch;
    logic       ten;
    logic       mt;
    logic [9:0] s;
    logic [9:0] s2;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ACSR_OFF_SC1, 32'h1f);
    check(chsel, 5'h1f);
    rdc(`ACSR_OFF_SC2, 32'h0);
    rdc(`ACSR_OFF_RH, 32'h0);
    m.xfer(1'b0, 8'h18, 32'h0, rd, er);
    check(er, 1'b1);
    check(rd, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      ten = i[0];
      ch = (i < 5) ? chs[i] : 5'($unsigned($random(seed)) % 28);
      s = 10'($random(seed));
      wr(`ACSR_OFF_CFG, ten ? 32'h8 : 32'h0);
      convert(s, {3'b010, ch});
      check(chsel, ch);
      check(pwr, 1'b0);
      check(irq, 1'b1);
      rdc(`ACSR_OFF_SC1, {24'h0, 3'b110, ch});
      rdc(`ACSR_OFF_SC2, 32'h0);
      rdc(`ACSR_OFF_RH, rh_of(s, ten));
      rdc(`ACSR_OFF_RL, rl_of(s, ten));
      rdc(`ACSR_OFF_SC1, {24'h0, 3'b010, ch});
      check(irq, 1'b0);
    end
    $display("single conversion test done");
    for (int t = 0; t < 2; t++) begin
      ten = (t == 0);
      s = 10'($random(seed));
      wr(`ACSR_OFF_CFG, ten ? 32'h8 : 32'h0);
      convert(s, 8'h01);
      rdc(`ACSR_OFF_RH, rh_of(s, ten));
      convert(~s, 8'h01);
      rdc(`ACSR_OFF_RL, rl_of(ten ? s : ~s, ten));
    end
    $display("interlock test done");
    for (int j = 0; j < 7; j++) begin
      ten = tg[j][1];
      s = sss[j];
      wr(`ACSR_OFF_CFG, ten ? 32'h8 : 32'h0);
      wr(`ACSR_OFF_SC2, 32'h0);
      convert(~s, 8'h01);
      wr(`ACSR_OFF_CV, {22'h0, cvs[j]});
      wr(`ACSR_OFF_SC2, {26'h0, 1'b1, tg[j][0], 4'h3});
      rdc(`ACSR_OFF_SC2, {26'h0, 1'b1, tg[j][0], 4'h0});
      convert(s, 8'h01);
      mt = hit(s, ten, tg[j][0], cvs[j]);
      rdc(`ACSR_OFF_SC1, {24'h0, mt, 7'h01});
      rdc(`ACSR_OFF_RL, rl_of(mt ? s : ~s, ten));
    end
    wr(`ACSR_OFF_SC2, 32'h0);
    wr(`ACSR_OFF_CFG, 32'h0);
    $display("compare test done");
    smp <= 10'($random(seed));
    wr(`ACSR_OFF_SC1, 32'h05);
    wait_pw(1'b1, 8);
    wr(`ACSR_OFF_SC1, 32'h1f);
    tick(2);
    check(pwr, 1'b0);
    rdc(`ACSR_OFF_SC2, 32'h0);
    rdc(`ACSR_OFF_SC1, 32'h1f);
    $display("abort test done");
    s = 10'($random(seed));
    wr(`ACSR_OFF_SC2, 32'h40);
    smp <= s;
    wr(`ACSR_OFF_SC1, 32'h03);
    tick(CC + 6);
    check(pwr, 1'b0);
    hw <= 1'b1;
    wait_pw(1'b1, 8);
    wait_pw(1'b0, CC + 12);
    // trigger still high: a level must not start another conversion
    tick(CC + 8);
    check(pwr, 1'b0);
    rdc(`ACSR_OFF_SC1, 32'h83);
    rdc(`ACSR_OFF_RL, {24'h0, s[9:2]});
    hw <= 1'b0;
    wr(`ACSR_OFF_SC2, 32'h0);
    $display("hardware trigger test done");
    s = 10'($random(seed));
    s2 = ~s;
    smp <= s;
    wr(`ACSR_OFF_SC1, 32'h22);
    tick(CC + 8);
    smp <= s2;
    tick(2 * CC + 12);
    rdc(`ACSR_OFF_RL, {24'h0, s2[9:2]});
    wr(`ACSR_OFF_SC1, 32'h1f);
    smp <= s;
    tick(2 * CC + 12);
    check(pwr, 1'b0);
    check(chsel, 5'h1f);
    rdc(`ACSR_OFF_RL, {24'h0, s2[9:2]});
    $display("continuous test done");
    end_of_test();
  end
endmodule : test_adc_control_status_result_high
